// [hdl/irq_enable_mask.sv]
// interrupt enable masking: enable registers, identifier, pin gating and block events
module irq_enable_mask #(
  parameter bit DUAL_CHANNEL = 1'b1
) (
  input  wire logic                           core_clk,
  input  wire logic                           rst_b,
  input  wire irq_mask_pkg::reg_req_t         reg_req,
  output logic [7:0]                          reg_rdata,
  input  wire irq_mask_pkg::primary_flags_t   primary_flags,
  input  wire irq_mask_pkg::secondary_flags_t secondary_flags,
  output logic                                irq_out_n,
  output logic                                block_irq
);
  import irq_mask_pkg::*;

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    primary_irq_en_t   en1;
    secondary_irq_en_t en2;
    logic [7:0]        rdata;
    logic              irq_n;
    logic              pending_d;
  } state_t;

  state_t state_reg;
  state_t state_next;

  localparam logic [7:0] CHIP_ID = DUAL_CHANNEL ? ID_DUAL_CHANNEL : ID_SINGLE_CHANNEL;

  // ***************************************************
  // helpers
  // ***************************************************
  function automatic logic masked_hit(input logic [7:0] flags, input logic [7:0] enables);
    masked_hit = |(flags & enables);
  endfunction : masked_hit

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == OFS_IRQ_ENABLE_PRIMARY)   ||
                (addr == OFS_IRQ_ENABLE_SECONDARY) ||
                (addr == OFS_CHIP_IDENTIFIER)      ||
                (addr == OFS_BLOCK_EVENT_STATUS)   ||
                (addr == OFS_BLOCK_EVENT_MASK)     ||
                (addr == OFS_ENABLED_PENDING);
  endfunction : is_mapped

  // ***************************************************
  // flag gating
  // ***************************************************
  logic [7:0] pend1;
  logic [7:0] pend2;
  logic       pending;

  // reserved flag bits can never reach the pin since their enables stay zero
  assign pend1   = primary_flags & state_reg.en1;
  assign pend2   = secondary_flags & state_reg.en2;
  assign pending = masked_hit(primary_flags, state_reg.en1) ||
                   masked_hit(secondary_flags, state_reg.en2);

  // ***************************************************
  // block events
  // ***************************************************
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;
  logic             wr_evt_status;
  logic             wr_evt_mask;

  always_comb begin
    evt_set               = '0;
    evt_set[EVT_IRQ_RISE] = pending && !state_reg.pending_d;
    evt_set[EVT_RO_WRITE] = reg_req.wr && (reg_req.addr == OFS_CHIP_IDENTIFIER ||
                                           reg_req.addr == OFS_ENABLED_PENDING);
    evt_set[EVT_UNMAPPED] = (reg_req.wr || reg_req.rd) && !is_mapped(reg_req.addr);
  end

  assign wr_evt_status = reg_req.wr && (reg_req.addr == OFS_BLOCK_EVENT_STATUS);
  assign wr_evt_mask   = reg_req.wr && (reg_req.addr == OFS_BLOCK_EVENT_MASK);

  event_sticky #(
    .WIDTH (EVT_W)
  ) u_events (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .set_pulse (evt_set),
    .clear_stb (wr_evt_status),
    .mask_stb  (wr_evt_mask),
    .wr_bits   (reg_req.wdata[EVT_W-1:0]),
    .status    (evt_status),
    .mask      (evt_mask),
    .irq       (block_irq)
  );

  // ***************************************************
  // register file and pin
  // ***************************************************
  always_comb begin
    state_next           = state_reg;
    state_next.irq_n     = !pending;
    state_next.pending_d = pending;
    state_next.rdata     = RST_RDATA;
    if (reg_req.wr) begin
      case (reg_req.addr)
        OFS_IRQ_ENABLE_PRIMARY: begin
          state_next.en1 = reg_req.wdata & WMASK_PRIMARY;
        end
        OFS_IRQ_ENABLE_SECONDARY: begin
          state_next.en2 = reg_req.wdata & WMASK_SECONDARY;
        end
        default: begin
          // identifier and unmapped writes only raise an event
          state_next.en1 = state_reg.en1;
        end
      endcase
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        OFS_IRQ_ENABLE_PRIMARY: begin
          state_next.rdata = state_reg.en1;
        end
        OFS_IRQ_ENABLE_SECONDARY: begin
          state_next.rdata = state_reg.en2;
        end
        OFS_CHIP_IDENTIFIER: begin
          state_next.rdata = CHIP_ID;
        end
        OFS_BLOCK_EVENT_STATUS: begin
          state_next.rdata = {{(8-EVT_W){1'b0}}, evt_status};
        end
        OFS_BLOCK_EVENT_MASK: begin
          state_next.rdata = {{(8-EVT_W){1'b0}}, evt_mask};
        end
        OFS_ENABLED_PENDING: begin
          state_next.rdata = {pending, 3'h0, pend2[7], |pend1[7:4], |pend1[3:1], 1'b0};
        end
        default: begin
          state_next.rdata = RST_RDATA;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg.en1       <= RST_ENABLE;
      state_reg.en2       <= RST_ENABLE;
      state_reg.rdata     <= RST_RDATA;
      state_reg.irq_n     <= 1'b1;
      state_reg.pending_d <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // one-cycle pipeline on the pin keeps it glitch free
  assign irq_out_n = state_reg.irq_n;
  assign reg_rdata = state_reg.rdata;

  // ***************************************************
  // checks
  // ***************************************************
  default clocking chk_clk @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  chk_exposure_gate: assert property (
    primary_flags.exposure_overflow_flag && state_reg.en1.exposure_overflow_irq_en |=> !irq_out_n)
    else $error("exposure overflow did not assert pin");

  chk_limit_two_gate: assert property (
    primary_flags.limit_two_cross_flag && state_reg.en1.limit_two_cross_irq_en |=> !irq_out_n)
    else $error("threshold two did not assert pin");

  chk_limit_one_gate: assert property (
    primary_flags.limit_one_cross_flag && state_reg.en1.limit_one_cross_irq_en |=> !irq_out_n)
    else $error("threshold one did not assert pin");

  chk_invalid_cfg_gate: assert property (
    secondary_flags.invalid_config_flag && state_reg.en2.invalid_config_irq_en |=> !irq_out_n)
    else $error("invalid configuration did not assert pin");

  chk_emitter4_gate: assert property (
    secondary_flags.emitter4_compliance_flag && state_reg.en2.emitter4_compliance_irq_en |=> !irq_out_n)
    else $error("emitter four compliance did not assert pin");

  chk_emitter3_gate: assert property (
    secondary_flags.emitter3_compliance_flag && state_reg.en2.emitter3_compliance_irq_en |=> !irq_out_n)
    else $error("emitter three compliance did not assert pin");

  chk_emitter2_gate: assert property (
    secondary_flags.emitter2_compliance_flag && state_reg.en2.emitter2_compliance_irq_en |=> !irq_out_n)
    else $error("emitter two compliance did not assert pin");

  chk_emitter1_gate: assert property (
    secondary_flags.emitter1_compliance_flag && state_reg.en2.emitter1_compliance_irq_en |=> !irq_out_n)
    else $error("emitter one compliance did not assert pin");

  chk_identifier_read: assert property (
    reg_req.rd && reg_req.addr == OFS_CHIP_IDENTIFIER |=> reg_rdata == CHIP_ID)
    else $error("identifier read returned wrong code");

  chk_identifier_write: assert property (
    reg_req.wr && reg_req.addr == OFS_CHIP_IDENTIFIER |=> $stable(state_reg.en1) && $stable(state_reg.en2))
    else $error("identifier write changed enables");

  chk_almost_full_gate: assert property (
    primary_flags.almost_full_flag && state_reg.en1.almost_full_irq_en |=> !irq_out_n)
    else $error("almost full did not assert pin");

  chk_frame_ready_gate: assert property (
    primary_flags.frame_ready_flag && state_reg.en1.frame_ready_irq_en |=> !irq_out_n)
    else $error("frame ready did not assert pin");

  chk_data_ready_gate: assert property (
    primary_flags.fifo_data_ready_flag && state_reg.en1.fifo_data_ready_irq_en |=> !irq_out_n)
    else $error("fifo data ready did not assert pin");

  chk_ambient_gate: assert property (
    primary_flags.ambient_cancel_overflow_flag && state_reg.en1.ambient_cancel_overflow_irq_en
    |=> !irq_out_n)
    else $error("ambient cancel overflow did not assert pin");

  chk_pin_release: assert property (
    !masked_hit(primary_flags, state_reg.en1) && !masked_hit(secondary_flags, state_reg.en2)
    |=> irq_out_n)
    else $error("pin held low with no enabled flag");

  chk_masked_quiet: assert property (
    state_reg.en1 == RST_ENABLE && state_reg.en2 == RST_ENABLE |=> irq_out_n)
    else $error("pin asserted with all enables clear");

  chk_reserved_zero: assert property (
    reg_req.rd && reg_req.addr == OFS_IRQ_ENABLE_SECONDARY |=> reg_rdata[6:4] == 3'h0)
    else $error("reserved secondary bits read nonzero");

  chk_reserved_primary: assert property (
    reg_req.wr && reg_req.addr == OFS_IRQ_ENABLE_PRIMARY ##1 reg_req.rd &&
    reg_req.addr == OFS_IRQ_ENABLE_PRIMARY |=> reg_rdata[0] == 1'b0)
    else $error("reserved primary bit read nonzero");

  chk_rdata_single: assert property (
    !reg_req.rd |=> reg_rdata == RST_RDATA)
    else $error("read data stood beyond one cycle");

  cov_pin_assert: cover property (irq_out_n ##1 !irq_out_n ##[1:8] irq_out_n);
  cov_id_read:    cover property (reg_req.rd && reg_req.addr == OFS_CHIP_IDENTIFIER);
  cov_evt_clear:  cover property (block_irq ##1 wr_evt_status ##1 !block_irq);
  cov_unmapped:   cover property (evt_set[EVT_UNMAPPED]);

endmodule : irq_enable_mask

// [hdl/irq_mask_pkg.sv]
// package: register map, field layouts and reset values of the interrupt enable masking block
package irq_mask_pkg;

  // ***************************************************
  // register map
  // ***************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] OFS_IRQ_ENABLE_PRIMARY   = 8'h58;
  localparam logic [7:0] OFS_IRQ_ENABLE_SECONDARY = 8'h59;
  localparam logic [7:0] OFS_CHIP_IDENTIFIER      = 8'hff;
  localparam logic [7:0] OFS_BLOCK_EVENT_STATUS   = 8'h60;
  localparam logic [7:0] OFS_BLOCK_EVENT_MASK     = 8'h61;
  localparam logic [7:0] OFS_ENABLED_PENDING      = 8'h62;

  // writable bits; the rest are reserved
  localparam logic [7:0] WMASK_PRIMARY   = 8'hfe;
  localparam logic [7:0] WMASK_SECONDARY = 8'h8f;
  localparam logic [7:0] RST_ENABLE      = 8'h00;
  localparam logic [7:0] RST_RDATA       = 8'h00;

  // identifier codes, values arbitrary
  localparam logic [7:0] ID_DUAL_CHANNEL   = 8'h5a;
  localparam logic [7:0] ID_SINGLE_CHANNEL = 8'h5b;

  // block event bits
  localparam int unsigned EVT_W        = 3;
  localparam int unsigned EVT_IRQ_RISE = 0;
  localparam int unsigned EVT_RO_WRITE = 1;
  localparam int unsigned EVT_UNMAPPED = 2;
  localparam logic [2:0]  RST_EVENT    = 3'h0;

  // ***************************************************
  // carriers
  // ***************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic almost_full_flag;
    logic frame_ready_flag;
    logic fifo_data_ready_flag;
    logic ambient_cancel_overflow_flag;
    logic exposure_overflow_flag;
    logic limit_two_cross_flag;
    logic limit_one_cross_flag;
    logic spare;
  } primary_flags_t;

  typedef struct packed {
    logic       invalid_config_flag;
    logic [2:0] spare;
    logic       emitter4_compliance_flag;
    logic       emitter3_compliance_flag;
    logic       emitter2_compliance_flag;
    logic       emitter1_compliance_flag;
  } secondary_flags_t;

  typedef struct packed {
    logic almost_full_irq_en;
    logic frame_ready_irq_en;
    logic fifo_data_ready_irq_en;
    logic ambient_cancel_overflow_irq_en;
    logic exposure_overflow_irq_en;
    logic limit_two_cross_irq_en;
    logic limit_one_cross_irq_en;
    logic spare;
  } primary_irq_en_t;

  typedef struct packed {
    logic       invalid_config_irq_en;
    logic [2:0] spare;
    logic       emitter4_compliance_irq_en;
    logic       emitter3_compliance_irq_en;
    logic       emitter2_compliance_irq_en;
    logic       emitter1_compliance_irq_en;
  } secondary_irq_en_t;

endpackage : irq_mask_pkg

// [hdl/event_sticky.sv]
// sticky event status with write-one-to-clear, mask and level interrupt
module event_sticky #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] set_pulse,
  input  wire logic             clear_stb,
  input  wire logic             mask_stb,
  input  wire logic [WIDTH-1:0] wr_bits,
  output logic      [WIDTH-1:0] status,
  output logic      [WIDTH-1:0] mask,
  output logic                  irq
);
  import irq_mask_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] status;
    logic [WIDTH-1:0] mask;
  } sticky_state_t;

  sticky_state_t state_reg;
  sticky_state_t state_next;

  // set wins over a same-cycle clear
  always_comb begin
    state_next = state_reg;
    if (clear_stb) begin
      state_next.status = state_reg.status & ~wr_bits;
    end
    state_next.status = state_next.status | set_pulse;
    if (mask_stb) begin
      state_next.mask = wr_bits;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign status = state_reg.status;
  assign mask   = state_reg.mask;
  assign irq    = |(state_reg.status & state_reg.mask);

endmodule : event_sticky

// [testbench/host_model.sv]
// host side model: register bus master and watcher of the interrupt pin
module host_model (
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire logic [7:0]             reg_rdata,
  input  wire logic                   irq_out_n,
  output irq_mask_pkg::reg_req_t      reg_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_mask_pkg::*;

  int pin_asserts;

  initial begin
    reg_req     = '0;
    pin_asserts = 0;
  end

  // counts pin assertions so the bench can see the host was really interrupted
  always @(negedge irq_out_n) begin
    if (rst_b) begin
      pin_asserts++;
    end
  end

  // one-cycle write strobe; slave never stalls
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    reg_req.wr    <= 1'b1;
    @(posedge core_clk);
    reg_req.wr    <= 1'b0;
  endtask : reg_write

  // data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_req.addr <= a;
    reg_req.rd   <= 1'b1;
    @(posedge core_clk);
    reg_req.rd   <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : reg_read

  // write then read of one register, strobes back to back with no idle cycle
  task automatic reg_write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    reg_req.wr    <= 1'b1;
    @(posedge core_clk);
    reg_req.wr    <= 1'b0;
    reg_req.rd    <= 1'b1;
    @(posedge core_clk);
    reg_req.rd    <= 1'b0;
    @(posedge core_clk);
    q = reg_rdata;
  endtask : reg_write_read

endmodule : host_model

// [testbench/tb.sv]
// self-checking bench for the interrupt enable masking block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_mask_pkg::*;

  localparam logic [15:0] WM = {WMASK_SECONDARY, WMASK_PRIMARY};

  logic             core_clk;
  logic             rst_b;
  reg_req_t         reg_req;
  logic [7:0]       reg_rdata;
  primary_flags_t   primary_flags;
  secondary_flags_t secondary_flags;
  logic             irq_out_n;
  logic             block_irq;
  int               n_fail;
  int               check_count;
  int               cycles;
  logic [7:0]       rd_val;
  logic [15:0]      en;
  logic [15:0]      fl;

  irq_enable_mask dut (
    .core_clk       (core_clk),
    .rst_b          (rst_b),
    .reg_req        (reg_req),
    .reg_rdata      (reg_rdata),
    .primary_flags  (primary_flags),
    .secondary_flags(secondary_flags),
    .irq_out_n      (irq_out_n),
    .block_irq      (block_irq)
  );

  host_model host (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .reg_rdata(reg_rdata),
    .irq_out_n(irq_out_n),
    .reg_req  (reg_req)
  );

  always #20 core_clk = ~core_clk;

  // ***************************************************
  // expectation and reporting
  // ***************************************************
  function automatic logic exp_pin(input logic [15:0] e, input logic [15:0] f);
    return ~(|(e & f & WM));
  endfunction : exp_pin

  // pending view: bit7 any, bit3 invalid config, bit2 primary 7..4, bit1 primary 3..1
  function automatic logic [7:0] exp_view(input logic [15:0] e, input logic [15:0] f);
    logic [15:0] p;
    p = e & f & WM;
    return {|p, 3'h0, p[15], |p[7:4], |p[3:1], 1'b0};
  endfunction : exp_view

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // flags land together with the secondary enables, pin is looked at after its one-edge delay
  task automatic pin_case(input logic [15:0] e, input logic [15:0] f);
    host.reg_write(OFS_IRQ_ENABLE_PRIMARY, e[7:0]);
    host.reg_write(OFS_IRQ_ENABLE_SECONDARY, e[15:8]);
    primary_flags   <= primary_flags_t'(f[7:0]);
    secondary_flags <= secondary_flags_t'(f[15:8]);
    @(posedge core_clk);
    @(posedge core_clk);
    check("irq_out_n", {7'h0, exp_pin(e, f)}, {7'h0, irq_out_n});
  endtask : pin_case

  // hang guard, generous for about 900 cycles of tests
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    core_clk        = 1'b0;
    rst_b           = 1'b0;
    primary_flags   = '0;
    secondary_flags = '0;
    n_fail          = 0;
    check_count     = 0;
    cycles          = 0;
    void'($urandom(8));
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;

    check("pin after reset", 8'h01, {7'h0, irq_out_n});
    check("block_irq after reset", 8'h00, {7'h0, block_irq});
    host.reg_read(OFS_IRQ_ENABLE_PRIMARY, rd_val);
    check("primary enable reset", RST_ENABLE, rd_val);
    host.reg_read(OFS_IRQ_ENABLE_SECONDARY, rd_val);
    check("secondary enable reset", RST_ENABLE, rd_val);
    $display("test reset values done");

    host.reg_write(OFS_IRQ_ENABLE_SECONDARY, 8'hff);
    host.reg_write_read(OFS_IRQ_ENABLE_PRIMARY, 8'hff, rd_val);
    check("primary reserved", 8'hfe, rd_val);
    host.reg_read(OFS_IRQ_ENABLE_SECONDARY, rd_val);
    check("secondary reserved", 8'h8f, rd_val);
    pin_case(16'hffff, ~WM);
    $display("test reserved bits done");

    // each source alone, each source masked while all others enabled, and the reverse
    for (int b = 0; b < 16; b++) begin
      if (WM[b]) begin
        pin_case(16'h1 << b, 16'h1 << b);
        pin_case(WM & ~(16'h1 << b), 16'h1 << b);
        pin_case(16'h1 << b, WM & ~(16'h1 << b));
      end
    end
    check("host saw pin", 8'h01, {7'h0, host.pin_asserts > 0});
    $display("test single sources done");

    repeat (40) begin
      en = 16'($urandom);
      fl = 16'($urandom);
      pin_case(en, fl);
      host.reg_read(OFS_ENABLED_PENDING, rd_val);
      check("pending view", exp_view(en, fl), rd_val);
      host.reg_read(OFS_IRQ_ENABLE_PRIMARY, rd_val);
      check("primary readback", en[7:0] & 8'hfe, rd_val);
      host.reg_read(OFS_IRQ_ENABLE_SECONDARY, rd_val);
      check("secondary readback", en[15:8] & 8'h8f, rd_val);
    end
    pin_case(16'h0, 16'h0);
    $display("test random mix done");

    host.reg_write(OFS_BLOCK_EVENT_STATUS, 8'h07);
    host.reg_write(OFS_CHIP_IDENTIFIER, 8'h00);
    host.reg_read(OFS_CHIP_IDENTIFIER, rd_val);
    check("identifier", ID_DUAL_CHANNEL, rd_val);
    host.reg_read(8'h10, rd_val);
    check("unmapped read", 8'h00, rd_val);
    host.reg_read(OFS_BLOCK_EVENT_STATUS, rd_val);
    check("event status", 8'h06, rd_val);
    check("block_irq masked", 8'h00, {7'h0, block_irq});
    host.reg_write(OFS_BLOCK_EVENT_MASK, 8'h04);
    @(posedge core_clk);
    check("block_irq raised", 8'h01, {7'h0, block_irq});
    host.reg_write(OFS_BLOCK_EVENT_STATUS, 8'h04);
    @(posedge core_clk);
    check("block_irq cleared", 8'h00, {7'h0, block_irq});
    host.reg_write(OFS_BLOCK_EVENT_STATUS, 8'h07);
    pin_case(16'h0008, 16'h0008);
    host.reg_write(OFS_ENABLED_PENDING, 8'hff);
    host.reg_read(OFS_BLOCK_EVENT_STATUS, rd_val);
    check("pin rise and read-only write events", 8'h03, rd_val);
    $display("test identifier and events done");

    finish_test();
  end

endmodule : tb
